// file: core/pwr_status_pkg.sv
// Purpose: Shared constants and types for the port power status block
// Assumes: Byte-wide registers reached over a two-wire SMBus slave
// Notes:   Bit positions and masks are named here and nowhere else
package pwr_status_pkg;

  // ==========================================================
  // Register map and sizes
  localparam int        PORTS       = 2;
  localparam logic [7:0] OFS_CUR1   = 8'h00;
  localparam logic [7:0] OFS_CUR2   = 8'h01;
  localparam logic [7:0] OFS_STAT   = 8'h02;
  localparam logic [7:0] OFS_INT1   = 8'h03;
  localparam logic [7:0] OFS_INT2   = 8'h04;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [6:0] SMB_ADDR_DEF = 7'h2C; // Arbitrary default address

  // Current reading scale: microamps per count, counts at full scale
  localparam int CUR_LSB_UA  = 13300;
  localparam int CUR_FULL    = 255;
  localparam int BACK_BIAS_MV = 150; // Comparator margin, analog side

  // ==========================================================
  // Fault status bit positions
  localparam int B_ERR   = 7;
  localparam int B_DISCH = 6;
  localparam int B_RST   = 5;  // Port 1 register only
  localparam int B_UV    = 5;  // Port 2 register only
  localparam int B_KEEP  = 4;
  localparam int B_THSD  = 3;  // Port 1 register only
  localparam int B_THRT  = 3;  // Port 2 register only
  localparam int B_OVV   = 2;  // Port 1 register only
  localparam int B_BACK  = 1;
  localparam int B_OVC   = 0;

  // Port status bit positions
  localparam int S_AL2 = 7;
  localparam int S_AL1 = 6;
  localparam int S_CC2 = 5;
  localparam int S_CC1 = 4;
  localparam int S_AT2 = 1;
  localparam int S_AT1 = 0;

  // Per-port masks, index 0 is port 1
  localparam logic [7:0] COR_MASK   [PORTS] = '{8'h7F, 8'h5B};
  localparam logic [7:0] LIVE_MASK  [PORTS] = '{8'h00, 8'h20};
  localparam logic [7:0] FAULT_MASK [PORTS] = '{8'h5F, 8'h53};
  localparam logic [7:0] SHARED_MASK = 8'h0C; // Port 1 bits alerting both
  localparam logic [7:0] ERR_MASK    = 8'h80;
  localparam logic [7:0] FLAG_RST   [PORTS] = '{8'h20, 8'h00};

  // ==========================================================
  // Types
  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic cc_mode;
    logic disch_fail;
    logic low_out;
    logic rev_bias;
    logic over_ilim;
    logic over_r2min;
    logic switch_on;
    logic discharging;
    logic power_en;
    logic alert_link;
    logic autorec;
    logic attach;
  } port_sense_t;

  typedef struct packed {
    logic over_temp;
    logic supply_ov;
    logic supply_uv;
    logic thermal_reg;
    logic sleep_detect;
    logic active;
  } glob_sense_t;

  typedef enum {
    SM_IDLE, SM_ADDR, SM_ACK_A, SM_CMD, SM_ACK_C,
    SM_WDATA, SM_RDATA, SM_RACK, SM_SKIP
  } smb_state_t;

endpackage : pwr_status_pkg

// file: core/pwr_status_regs.sv
// Purpose: Current readings, port status and fault status registers
// Assumes: Analog comparators arrive as asynchronous digital levels
// Notes:   Host access is a byte-wide SMBus slave with a register pointer
//
// Behaviour
// - Two read-only current counts at 00h, 01h
// - Zero count on sleep, detect, switch off, discharge
// - Refresh counts continuously while Active
// - Status bits 7,6 mirror port alert pins
// - Status bits 5,4 show constant-current mode
// - Status bits 1,0 mirror attach pins
// - Error bit sets on Error, zero when Active
// - Writing error zero rechecks faults before Active
// - Other set bits keep port in Error unless power disabled
// - Auto-recovery or power disable clears error bit
// - Fault flags clear on read once gone
// - Discharge failure sets bit 6
// - Reset flag at power-up, clears read/toggle
// - Low output voltage sets keep-out bit 4
// - Thermal and overvoltage alert both ports
// - Back bias sets bit 1
// - Overcurrent needs both current thresholds exceeded
// - Alert pins independent of error bit
// - Undervoltage bit live, holds switches off
// - Thermal throttle flag alerts only when linked
// - Port 2 bit 2 always zero
// - Registers over SMBus; unused bits read zero
`timescale 1ns/1ps
module pwr_status_regs
  import pwr_status_pkg::*;
#(
  parameter logic [6:0] SMB_ADDR = SMB_ADDR_DEF
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        smb_clk_in,
  input  wire logic        smb_dat_in,
  output logic             smb_dat_out,
  output logic             smb_dat_oe,
  input  wire port_sense_t p1_sense,
  input  wire port_sense_t p2_sense,
  input  wire glob_sense_t glob_sense,
  input  wire byte_t       p1_current_in,
  input  wire byte_t       p2_current_in,
  output logic             p1_alert_n,
  output logic             p2_alert_n,
  output logic             p1_attach_out_n,
  output logic             p2_attach_out_n,
  output logic [1:0]       port_error,
  output logic             switch_hold_off
);

  // ==========================================================
  // Input synchronisers
  localparam int SW = $bits(glob_sense_t) + 2 * $bits(port_sense_t) + 18;
  // Bus wires idle high; starting there avoids a false edge after reset
  localparam logic [SW-1:0] SYNC_IDLE = {{(SW-2){1'b0}}, 2'b11};
  logic [SW-1:0] raw, s1_r, s2_r, s3_r, stb_r, stb_nxt;
  glob_sense_t   g;
  port_sense_t   ps [PORTS];
  byte_t         cur_in [PORTS];
  logic          scl, sda;

  assign raw = {glob_sense, p2_sense, p1_sense, p2_current_in,
                p1_current_in, smb_clk_in, smb_dat_in};
  assign {g, ps[1], ps[0], cur_in[1], cur_in[0], scl, sda} = stb_r;

  // A bit moves only when stages two and three agree
  // Limitation: a multi-bit current sample may mix two readings once
  always_comb begin
    stb_nxt = (s2_r & s3_r) | (stb_r & (s2_r | s3_r));
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r  <= SYNC_IDLE;
      s2_r  <= SYNC_IDLE;
      s3_r  <= SYNC_IDLE;
      stb_r <= SYNC_IDLE;
    end else begin
      s1_r  <= raw;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      stb_r <= stb_nxt;
    end
  end

  // ==========================================================
  // Register state
  byte_t      cur_r [PORTS], cur_nxt [PORTS];
  byte_t      flg_r [PORTS], flg_nxt [PORTS];
  logic [1:0] alert_n_r, alert_n_nxt, att_n_r, att_n_nxt;
  logic       uv_r, uv_nxt, pe1_q_r;
  byte_t      stat;

  // Port status view; alert and attach bits from the driven pin flops
  always_comb begin
    stat        = ZERO_BYTE;
    stat[S_AL2] = ~alert_n_r[1];
    stat[S_AL1] = ~alert_n_r[0];
    stat[S_CC2] = ps[1].cc_mode;
    stat[S_CC1] = ps[0].cc_mode;
    stat[S_AT2] = ~att_n_r[1];
    stat[S_AT1] = ~att_n_r[0];
  end

  // Read decode, shared by address ack and each next byte
  function automatic byte_t read_reg(input byte_t a);
    case (a)
      OFS_CUR1: read_reg = cur_r[0];
      OFS_CUR2: read_reg = cur_r[1];
      OFS_STAT: read_reg = stat;
      OFS_INT1: read_reg = flg_r[0];
      OFS_INT2: read_reg = flg_r[1];
      default:  read_reg = ZERO_BYTE;
    endcase
  endfunction : read_reg

  // ==========================================================
  // SMBus slave
  smb_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  byte_t      sh_r, sh_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt;
  byte_t      acc_a_r, acc_a_nxt, wd_r, wd_nxt;
  logic       rw_r, rw_nxt, oe_r, oe_nxt, rd_r, rd_nxt, wr_r, wr_nxt;
  logic       scl_q_r, sda_q_r;
  logic       start_c, stop_c, rise_c, fall_c;

  assign start_c = scl && scl_q_r && sda_q_r && !sda;
  assign stop_c  = scl && scl_q_r && !sda_q_r && sda;
  assign rise_c  = scl && !scl_q_r;
  assign fall_c  = !scl && scl_q_r;

  // Byte engine; a read snapshot is taken before any clear acts
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    tx_nxt    = tx_r;
    ptr_nxt   = ptr_r;
    rw_nxt    = rw_r;
    oe_nxt    = oe_r;
    acc_a_nxt = acc_a_r;
    wd_nxt    = wd_r;
    rd_nxt    = 1'b0;
    wr_nxt    = 1'b0;
    if (start_c) begin
      st_nxt  = SM_ADDR;
      cnt_nxt = '0;
      oe_nxt  = 1'b0;
    end else if (stop_c) begin
      st_nxt = SM_IDLE;
      oe_nxt = 1'b0;
    end else if (rise_c) begin
      case (st_r)
        SM_ADDR, SM_CMD, SM_WDATA: begin
          sh_nxt  = {sh_r[6:0], sda};
          cnt_nxt = cnt_r + 4'h1;
        end
        SM_RDATA: cnt_nxt = cnt_r + 4'h1;
        SM_RACK:  if (sda) st_nxt = SM_SKIP; // Master ended the read
        default: ;
      endcase
    end else if (fall_c) begin
      case (st_r)
        SM_ADDR: begin
          if (cnt_r == BYTE_BITS) begin
            if (sh_r[7:1] == SMB_ADDR) begin
              oe_nxt = 1'b1;
              rw_nxt = sh_r[0];
              st_nxt = SM_ACK_A;
            end else begin
              st_nxt = SM_SKIP;
            end
          end
        end
        SM_ACK_A, SM_RACK: begin
          cnt_nxt = '0;
          if (st_r == SM_RACK || rw_r) begin
            tx_nxt    = read_reg(ptr_r);
            acc_a_nxt = ptr_r;
            rd_nxt    = 1'b1;
            ptr_nxt   = 8'(ptr_r + 8'h01);
            oe_nxt    = ~tx_nxt[7];
            st_nxt    = SM_RDATA;
          end else begin
            oe_nxt = 1'b0;
            st_nxt = SM_CMD;
          end
        end
        SM_CMD: begin
          if (cnt_r == BYTE_BITS) begin
            oe_nxt  = 1'b1;
            ptr_nxt = sh_r;
            st_nxt  = SM_ACK_C;
          end
        end
        SM_WDATA: begin
          if (cnt_r == BYTE_BITS) begin
            oe_nxt    = 1'b1;
            wr_nxt    = 1'b1;
            wd_nxt    = sh_r;
            acc_a_nxt = ptr_r;
            ptr_nxt   = 8'(ptr_r + 8'h01);
            st_nxt    = SM_ACK_C;
          end
        end
        SM_ACK_C: begin
          oe_nxt  = 1'b0;
          cnt_nxt = '0;
          st_nxt  = SM_WDATA;
        end
        SM_RDATA: begin
          if (cnt_r == BYTE_BITS) begin
            oe_nxt = 1'b0;
            st_nxt = SM_RACK;
          end else begin
            tx_nxt = {tx_r[6:0], 1'b0};
            oe_nxt = ~tx_r[6];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r    <= SM_IDLE;
      cnt_r   <= '0;
      sh_r    <= ZERO_BYTE;
      tx_r    <= ZERO_BYTE;
      ptr_r   <= ZERO_BYTE;
      acc_a_r <= ZERO_BYTE;
      wd_r    <= ZERO_BYTE;
      rw_r    <= 1'b0;
      oe_r    <= 1'b0;
      rd_r    <= 1'b0;
      wr_r    <= 1'b0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      tx_r    <= tx_nxt;
      ptr_r   <= ptr_nxt;
      acc_a_r <= acc_a_nxt;
      wd_r    <= wd_nxt;
      rw_r    <= rw_nxt;
      oe_r    <= oe_nxt;
      rd_r    <= rd_nxt;
      wr_r    <= wr_nxt;
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end

  // ==========================================================
  // Fault flags, error latch and pins
  byte_t ofs_int [PORTS];
  assign ofs_int[0] = OFS_INT1;
  assign ofs_int[1] = OFS_INT2;

  always_comb begin
    byte_t cond, keep, others, clr;
    logic  any_c, err_clr, rd_hit, wr0, al;
    cond = ZERO_BYTE;
    keep = ZERO_BYTE;
    others = ZERO_BYTE;
    clr = ZERO_BYTE;
    any_c = 1'b0;
    err_clr = 1'b0;
    rd_hit = 1'b0;
    wr0 = 1'b0;
    al = 1'b0;
    uv_nxt = g.supply_uv; // Switches held off while supply is low
    for (int p = 0; p < PORTS; p++) begin
      cond          = ZERO_BYTE;
      cond[B_DISCH] = ps[p].disch_fail;
      cond[B_KEEP]  = ps[p].low_out;
      cond[B_BACK]  = ps[p].rev_bias;
      cond[B_OVC]   = ps[p].over_ilim && ps[p].over_r2min;
      if (p == 0) begin
        cond[B_THSD] = g.over_temp;
        cond[B_OVV] = g.supply_ov;
      end else begin
        cond[B_UV]   = g.supply_uv;
        cond[B_THRT] = g.thermal_reg;
      end
      any_c  = |(cond & FAULT_MASK[p]);
      others = flg_r[p] & ~ERR_MASK;
      rd_hit = rd_r && (acc_a_r == ofs_int[p]);
      wr0    = wr_r && (acc_a_r == ofs_int[p]) && !wd_r[B_ERR];
      // Leave Error with no fault and no other flag, or with no fault on power disable
      err_clr = flg_r[p][B_ERR] && (
                (wr0 && !any_c && others == ZERO_BYTE) ||
                (ps[p].autorec && !any_c && others == ZERO_BYTE) ||
                !ps[p].power_en);
      // Read clears only what has gone; error clear sweeps all
      clr = (rd_hit ? (COR_MASK[p] & ~cond) : ZERO_BYTE) |
            (err_clr ? COR_MASK[p] : ZERO_BYTE);
      keep = flg_r[p] & ~clr & ~LIVE_MASK[p] & ~ERR_MASK;
      // Set beats clear in the same cycle
      flg_nxt[p] = keep | (cond & COR_MASK[p]) | (cond & LIVE_MASK[p]);
      if (p == 0 && pe1_q_r != ps[0].power_en) begin
        flg_nxt[p][B_RST] = 1'b0;
      end
      flg_nxt[p][B_ERR] = (flg_r[p][B_ERR] && !err_clr) || any_c;
      // Pins follow flags, not the error latch
      al = |(flg_r[p] & FAULT_MASK[p]) |
           |(flg_r[0] & SHARED_MASK) |
           (flg_r[1][B_THRT] && ps[p].alert_link);
      alert_n_nxt[p] = ~al;
      att_n_nxt[p]   = ~ps[p].attach;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < PORTS; p++) begin
        flg_r[p] <= FLAG_RST[p];
      end
      alert_n_r <= '1;
      att_n_r   <= '1;
      uv_r      <= 1'b0;
      pe1_q_r   <= 1'b0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        flg_r[p] <= flg_nxt[p];
      end
      alert_n_r <= alert_n_nxt;
      att_n_r   <= att_n_nxt;
      uv_r      <= uv_nxt;
      pe1_q_r   <= ps[0].power_en;
    end
  end

  // ==========================================================
  // Current readings
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      if (g.sleep_detect || !ps[p].switch_on || ps[p].discharging) begin
        cur_nxt[p] = ZERO_BYTE;
      end else if (g.active) begin
        cur_nxt[p] = cur_in[p];
      end else begin
        cur_nxt[p] = cur_r[p];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < PORTS; p++) begin
        cur_r[p] <= ZERO_BYTE;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        cur_r[p] <= cur_nxt[p];
      end
    end
  end

  // Open-drain data: only ever pulls low
  assign smb_dat_out     = 1'b0;
  assign smb_dat_oe      = oe_r;
  assign p1_alert_n      = alert_n_r[0];
  assign p2_alert_n      = alert_n_r[1];
  assign p1_attach_out_n = att_n_r[0];
  assign p2_attach_out_n = att_n_r[1];
  assign port_error      = {flg_r[1][B_ERR], flg_r[0][B_ERR]};
  assign switch_hold_off = uv_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_cur_zero;
    !ps[0].switch_on |=> cur_r[0] == ZERO_BYTE;
  endproperty
  a_cur_zero: assert property (p_cur_zero)
    else $error("port 1 count not zeroed with switch off");

  property p_cur_track;
    (g.active && !g.sleep_detect && ps[1].switch_on &&
     !ps[1].discharging) |=> cur_r[1] == $past(cur_in[1]);
  endproperty
  a_cur_track: assert property (p_cur_track)
    else $error("port 2 count not refreshed");

  property p_ovc_alert;
    (ps[0].over_ilim && ps[0].over_r2min) |=> flg_r[0][B_OVC] &&
      flg_r[0][B_ERR] ##1 !p1_alert_n;
  endproperty
  a_ovc_alert: assert property (p_ovc_alert)
    else $error("overcurrent did not latch, enter error and alert");

  property p_hot_both;
    flg_r[0][B_THSD] |=> !p1_alert_n && !p2_alert_n;
  endproperty
  a_hot_both: assert property (p_hot_both)
    else $error("thermal shutdown did not alert both ports");

  property p_uv_live;
    flg_r[1][B_UV] == $past(g.supply_uv) && switch_hold_off == flg_r[1][B_UV];
  endproperty
  a_uv_live: assert property (p_uv_live)
    else $error("undervoltage bit not live");

  property p_bit2_zero;
    !flg_r[1][B_OVV];
  endproperty
  a_bit2_zero: assert property (p_bit2_zero)
    else $error("port 2 bit 2 read nonzero");

  property p_err_hold;
    (flg_r[1][B_ERR] && (flg_r[1] & ~ERR_MASK) != ZERO_BYTE &&
     ps[1].power_en) |=> flg_r[1][B_ERR];
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error left with flags still set");

  property p_keep_on_read;
    (rd_r && acc_a_r == OFS_INT2 && ps[1].rev_bias) |=> flg_r[1][B_BACK];
  endproperty
  a_keep_on_read: assert property (p_keep_on_read)
    else $error("flag lost while condition present at read");

  property p_pe_off_clears;
    (!ps[0].power_en && (flg_r[0] & FAULT_MASK[0]) == ZERO_BYTE &&
     !ps[0].disch_fail && !ps[0].low_out && !ps[0].rev_bias &&
     !(ps[0].over_ilim && ps[0].over_r2min) && !g.over_temp && !g.supply_ov)
      |=> !flg_r[0][B_ERR];
  endproperty
  a_pe_off_clears: assert property (p_pe_off_clears)
    else $error("power disable did not clear error bit");

endmodule : pwr_status_regs

// file: bench/smb_host.sv
// Purpose: Host microcontroller model driving the two-wire register bus
// Assumes: Data wire is pulled high whenever nobody pulls it low
// Notes:   Half periods of 12 clocks stay well above the sync latency
`timescale 1ns/1ps
module smb_host
  import pwr_status_pkg::*;
(
  input  wire logic mclk,
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda_low
);
  // ==========================================================
  // Bus idle: clock high, data released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge mclk);
  endtask : hw

  // Data moves only mid low phase, never beside a clock edge
  task automatic put(input logic b);
    sda_low <= ~b;
    hw(8);
    scl <= 1'b1;
    hw(12);
    scl <= 1'b0;
    hw(4);
  endtask : put

  task automatic get(output logic b);
    sda_low <= 1'b0;
    hw(8);
    scl <= 1'b1;
    hw(6);
    b = sda_in;
    hw(6);
    scl <= 1'b0;
    hw(4);
  endtask : get

  // ==========================================================
  // Framing; start also serves as repeated start
  task automatic start();
    sda_low <= 1'b0;
    hw(8);
    scl <= 1'b1;
    hw(12);
    sda_low <= 1'b1;
    hw(12);
    scl <= 1'b0;
    hw(4);
  endtask : start

  task automatic stop();
    sda_low <= 1'b1;
    hw(8);
    scl <= 1'b1;
    hw(12);
    sda_low <= 1'b0;
    hw(12);
  endtask : stop

  task automatic tx(input byte_t d, inout logic ok);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ok &= ~a;
  endtask : tx

  // ==========================================================
  // Register transfers with pointer byte
  task automatic write_reg(input byte_t a, input byte_t d,
                           output logic ok);
    ok = 1'b1;
    start();
    tx({SMB_ADDR_DEF, 1'b0}, ok);
    tx(a, ok);
    tx(d, ok);
    stop();
  endtask : write_reg

  task automatic read_reg(input byte_t a, output byte_t d,
                          output logic ok);
    ok = 1'b1;
    start();
    tx({SMB_ADDR_DEF, 1'b0}, ok);
    tx(a, ok);
    start();
    tx({SMB_ADDR_DEF, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    stop();
  endtask : read_reg
endmodule : smb_host

// file: bench/tb_port_power_status_error_regs.sv
// Purpose: Self-checking bench for the port power status registers
// Assumes: Sense inputs are slow levels; host reaches registers by bus
// Notes:   Waits of 10 clocks cover the input synchronisers
`timescale 1ns/1ps
module tb_port_power_status_error_regs
  import pwr_status_pkg::*;
;
  logic        mclk;
  logic        arst_n;
  port_sense_t p1_sense;
  port_sense_t p2_sense;
  glob_sense_t glob_sense;
  byte_t       p1_cur;
  byte_t       p2_cur;
  logic        scl;
  logic        sda_low;
  logic        sda;
  logic        dat_out;
  logic        dat_oe;
  logic        al1_n;
  logic        al2_n;
  logic        at1_n;
  logic        at2_n;
  logic [1:0]  port_error;
  logic        hold_off;
  logic [6:0]  obs;
  int          err_count;
  int          num_checks;

  // Open-drain data wire, pulled high
  assign sda = (dat_oe ? dat_out : 1'b1) & ~sda_low;
  assign obs = {at2_n, at1_n, hold_off, port_error, al2_n, al1_n};

  always #2.5 mclk = ~mclk;

  pwr_status_regs u_pwr_status_regs (
    .mclk(mclk), .arst_n(arst_n), .smb_clk_in(scl), .smb_dat_in(sda),
    .smb_dat_out(dat_out), .smb_dat_oe(dat_oe), .p1_sense(p1_sense),
    .p2_sense(p2_sense), .glob_sense(glob_sense),
    .p1_current_in(p1_cur), .p2_current_in(p2_cur),
    .p1_alert_n(al1_n), .p2_alert_n(al2_n), .p1_attach_out_n(at1_n),
    .p2_attach_out_n(at2_n), .port_error(port_error),
    .switch_hold_off(hold_off)
  );

  smb_host u_smb_host (
    .mclk(mclk), .sda_in(sda), .scl(scl), .sda_low(sda_low)
  );

  // ==========================================================
  // Helpers
  task automatic clk(input int n);
    repeat (n) @(posedge mclk);
  endtask : clk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input byte_t e, input byte_t g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", what, e, g);
      err_count++;
    end
  endtask : chk

  task automatic rd(input byte_t a, input byte_t e);
    byte_t d;
    logic  ok;
    u_smb_host.read_reg(a, d, ok);
    chk("ack", 8'h01, {7'h00, ok});
    chk($sformatf("reg %h", a), e, d);
  endtask : rd

  // Read that only empties clear-on-read flags
  task automatic drop(input byte_t a);
    byte_t d;
    logic  ok;
    u_smb_host.read_reg(a, d, ok);
  endtask : drop

  task automatic wr(input byte_t a, input byte_t d);
    logic ok;
    u_smb_host.write_reg(a, d, ok);
    chk("ack", 8'h01, {7'h00, ok});
  endtask : wr

  // Bounded poll; sel 0 al1 1 al2 2 p1_fault_latch 3 p2_fault_latch 4 hold 5 at1 6 at2
  task automatic lvl(input string what, input int sel, input logic v);
    int i;
    i = 0;
    while (obs[sel] !== v && i < 40) begin
      @(posedge mclk);
      i++;
    end
    num_checks++;
    if (obs[sel] !== v) begin
      $display("[ERR] %s exp %b got %b", what, v, obs[sel]);
      err_count++;
      end_of_test();
    end
  endtask : lvl

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rd(OFS_CUR2, ZERO_BYTE);
    rd(OFS_STAT, ZERO_BYTE);
    rd(OFS_INT2, ZERO_BYTE);
    rd(OFS_INT1, 8'h20);
    p1_sense.power_en <= 1'b1;
    p2_sense.power_en <= 1'b1;
    clk(10);
    rd(OFS_INT1, ZERO_BYTE);
    wr(OFS_CUR1, 8'hFF);
    rd(OFS_CUR1, ZERO_BYTE);
    rd(8'h05, ZERO_BYTE);
    $display("test reset done");
  endtask : t_reset

  task automatic t_current();
    glob_sense.active <= 1'b1;
    p1_sense.switch_on <= 1'b1;
    p2_sense.switch_on <= 1'b1;
    p1_cur <= 8'hA5;
    p2_cur <= 8'hFF;
    clk(10);
    rd(OFS_CUR1, 8'hA5);
    rd(OFS_CUR2, 8'hFF);
    p1_cur <= 8'h3C;
    clk(10);
    rd(OFS_CUR1, 8'h3C);
    p1_sense.switch_on <= 1'b0;
    clk(10);
    rd(OFS_CUR1, ZERO_BYTE);
    glob_sense.sleep_detect <= 1'b1;
    clk(10);
    rd(OFS_CUR2, ZERO_BYTE);
    glob_sense.sleep_detect <= 1'b0;
    clk(10);
    rd(OFS_CUR2, 8'hFF);
    p2_sense.discharging <= 1'b1;
    clk(10);
    rd(OFS_CUR2, ZERO_BYTE);
    p2_sense.discharging <= 1'b0;
    $display("test current done");
  endtask : t_current

  task automatic t_status();
    p2_sense.cc_mode <= 1'b1;
    p1_sense.attach <= 1'b1;
    clk(10);
    rd(OFS_STAT, 8'h21);
    lvl("attach1", 5, 1'b0);
    p2_sense.cc_mode <= 1'b0;
    p1_sense.cc_mode <= 1'b1;
    p1_sense.attach <= 1'b0;
    p2_sense.attach <= 1'b1;
    clk(10);
    rd(OFS_STAT, 8'h12);
    lvl("attach2", 6, 1'b0);
    p1_sense.cc_mode <= 1'b0;
    p2_sense.attach <= 1'b0;
    $display("test status done");
  endtask : t_status

  task automatic t_p1_fault();
    p1_sense.over_ilim <= 1'b1;
    clk(10);
    rd(OFS_INT1, ZERO_BYTE);
    p1_sense.over_r2min <= 1'b1;
    lvl("p1_fault_latch", 2, 1'b1);
    lvl("alert1", 0, 1'b0);
    rd(OFS_STAT, 8'h40);
    rd(OFS_INT1, 8'h81);
    rd(OFS_INT1, 8'h81);
    p1_sense.over_ilim <= 1'b0;
    clk(10);
    rd(OFS_INT1, 8'h81);
    rd(OFS_INT1, ERR_MASK);
    lvl("alert1", 0, 1'b1);
    lvl("p1_fault_latch", 2, 1'b1);
    wr(OFS_INT1, ZERO_BYTE);
    lvl("p1_fault_latch", 2, 1'b0);
    rd(OFS_INT1, ZERO_BYTE);
    p1_sense.over_r2min <= 1'b0;
    $display("test port1 fault done");
  endtask : t_p1_fault

  task automatic t_p2_fault();
    p2_sense.low_out <= 1'b1;
    lvl("p2_fault_latch", 3, 1'b1);
    lvl("alert2", 1, 1'b0);
    rd(OFS_INT2, 8'h90);
    wr(OFS_INT2, ZERO_BYTE);
    lvl("p2_fault_latch", 3, 1'b1);
    p2_sense.low_out <= 1'b0;
    clk(10);
    wr(OFS_INT2, ZERO_BYTE);
    lvl("p2_fault_latch", 3, 1'b1);
    rd(OFS_INT2, 8'h90);
    wr(OFS_INT2, ZERO_BYTE);
    lvl("p2_fault_latch", 3, 1'b0);
    rd(OFS_INT2, ZERO_BYTE);
    $display("test port2 fault done");
  endtask : t_p2_fault

  task automatic t_recover();
    p1_sense.disch_fail <= 1'b1;
    lvl("p1_fault_latch", 2, 1'b1);
    rd(OFS_INT1, 8'hC0);
    p1_sense.disch_fail <= 1'b0;
    p1_sense.power_en <= 1'b0;
    lvl("p1_fault_latch", 2, 1'b0);
    p1_sense.power_en <= 1'b1;
    clk(10);
    drop(OFS_INT1);
    p2_sense.rev_bias <= 1'b1;
    lvl("p2_fault_latch", 3, 1'b1);
    rd(OFS_INT2, 8'h82);
    p2_sense.rev_bias <= 1'b0;
    clk(10);
    rd(OFS_INT2, 8'h82);
    p2_sense.autorec <= 1'b1;
    lvl("p2_fault_latch", 3, 1'b0);
    p2_sense.autorec <= 1'b0;
    $display("test recovery done");
  endtask : t_recover

  // Both shared faults in turn, same clearing path
  task automatic t_global();
    for (int k = 0; k < 2; k++) begin
      glob_sense.over_temp <= (k == 0);
      glob_sense.supply_ov <= (k == 1);
      lvl("alert1", 0, 1'b0);
      lvl("alert2", 1, 1'b0);
      glob_sense.over_temp <= 1'b0;
      glob_sense.supply_ov <= 1'b0;
      clk(10);
      rd(OFS_INT1, (k == 0) ? 8'h88 : 8'h84);
      rd(OFS_INT1, ERR_MASK);
      wr(OFS_INT1, ZERO_BYTE);
      wr(OFS_INT2, ZERO_BYTE);
      lvl("p1_fault_latch", 2, 1'b0);
    end
    $display("test shared faults done");
  endtask : t_global

  task automatic t_supply();
    glob_sense.supply_uv <= 1'b1;
    lvl("hold_off", 4, 1'b1);
    rd(OFS_INT2, 8'h20);
    glob_sense.supply_uv <= 1'b0;
    lvl("hold_off", 4, 1'b0);
    rd(OFS_INT2, ZERO_BYTE);
    glob_sense.thermal_reg <= 1'b1;
    clk(10);
    lvl("alert2", 1, 1'b1);
    glob_sense.thermal_reg <= 1'b0;
    clk(10);
    rd(OFS_INT2, 8'h08);
    rd(OFS_INT2, ZERO_BYTE);
    p2_sense.alert_link <= 1'b1;
    glob_sense.thermal_reg <= 1'b1;
    lvl("alert2", 1, 1'b0);
    glob_sense.thermal_reg <= 1'b0;
    $display("test supply done");
  endtask : t_supply

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    p1_sense = '0;
    p2_sense = '0;
    glob_sense = '0;
    p1_cur = 8'h00;
    p2_cur = 8'h00;
    err_count = 0;
    num_checks = 0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    clk(10);
    t_reset();
    t_current();
    t_status();
    t_p1_fault();
    t_p2_fault();
    t_recover();
    t_global();
    t_supply();
    end_of_test();
  end

  initial begin
    repeat (95000) @(posedge mclk);
    err_count++;
    end_of_test();
  end
endmodule : tb_port_power_status_error_regs
